// file: design/tsw_consts.svh
`ifndef TSW_CONSTS_SVH
`define TSW_CONSTS_SVH

// write address layout
`define TSW_CHAN_LSB 8
`define TSW_INV_SEL_BIT 7
`define TSW_MID_HI 29
`define TSW_MID_LO 24
`define TSW_PROT_NS_BIT 1

// axi encodings
`define TSW_RESP_OKAY 2'h0
`define TSW_BURST_INCR 2'h1

// error packet payload
`define TSW_ERR_PAYLOAD 8'h00

// permitted strobe patterns
`define TSW_STRB_NONE 8'h00
`define TSW_STRB_B0 8'h01
`define TSW_STRB_B1 8'h02
`define TSW_STRB_B2 8'h04
`define TSW_STRB_B3 8'h08
`define TSW_STRB_B4 8'h10
`define TSW_STRB_B5 8'h20
`define TSW_STRB_B6 8'h40
`define TSW_STRB_B7 8'h80
`define TSW_STRB_H0 8'h03
`define TSW_STRB_H1 8'h0C
`define TSW_STRB_H2 8'h30
`define TSW_STRB_H3 8'hC0
`define TSW_STRB_W0 8'h0F
`define TSW_STRB_W1 8'hF0
`define TSW_STRB_D0 8'hFF

`endif

// file: design/tsw_pkg.sv
`default_nettype none
package tsw_pkg;
  typedef enum logic [2:0] {PK_NONE, PK_D8, PK_D16, PK_D32, PK_D64, PK_MASTER_ERROR_PACKET, PK_GLOBAL_ERROR_PACKET} pkt_kind_t;
  typedef enum logic [1:0] {WR_ADDR, WR_DATA, WR_RESP} wr_state_t;
  typedef enum logic {RD_ADDR, RD_DATA} rd_state_t;
  typedef enum logic [1:0] {OVR_NONE, OVR_INVARIANT, OVR_GUARANTEED} ovr_mode_t;
endpackage
`default_nettype wire

// file: design/tsw_fifo.sv
`default_nettype none
module tsw_fifo #(
  parameter int WIDTH = 75,
  parameter int DEPTH = 8,
  parameter int LW = $clog2(DEPTH + 1)
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LW-1:0] level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [LW-1:0] FULL = LW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [LW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  // full and empty come from the count, so neither lies on wrap
  assign in_ready = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];
  assign level = cnt_r;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count next values
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wp_nxt = (wp_r == LAST) ? '0 : wp_r + PW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == LAST) ? '0 : rp_r + PW'(1);
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + LW'(1);
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - LW'(1);
    end
  end

  // one storage word per slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_comb begin
      mem_nxt[i] = (push && wp_r == PW'(i)) ? in_data : mem_r[i];
    end
    always_ff @(posedge ref_clk) begin
      mem_r[i] <= mem_nxt[i];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  chk_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_r <= FULL) else $error("fifo count above depth");
endmodule
`default_nettype wire

// file: design/strobe_decode.sv
`default_nettype none
`include "tsw_consts.svh"
module strobe_decode (
  input wire logic [7:0] strb,
  input wire logic [63:0] wdata,
  output tsw_pkg::pkt_kind_t kind,
  output logic [63:0] payload
);
  import tsw_pkg::*;
  logic [2:0] lane;
  logic [63:0] shifted;

  // size and lane come from the strobes alone; low address bits never enter
  always_comb begin
    kind = PK_NONE;
    lane = 3'h0;
    case (strb)
      `TSW_STRB_B0: kind = PK_D8;
      `TSW_STRB_B1: begin kind = PK_D8; lane = 3'h1; end
      `TSW_STRB_B2: begin kind = PK_D8; lane = 3'h2; end
      `TSW_STRB_B3: begin kind = PK_D8; lane = 3'h3; end
      `TSW_STRB_B4: begin kind = PK_D8; lane = 3'h4; end
      `TSW_STRB_B5: begin kind = PK_D8; lane = 3'h5; end
      `TSW_STRB_B6: begin kind = PK_D8; lane = 3'h6; end
      `TSW_STRB_B7: begin kind = PK_D8; lane = 3'h7; end
      `TSW_STRB_H0: kind = PK_D16;
      `TSW_STRB_H1: begin kind = PK_D16; lane = 3'h2; end
      `TSW_STRB_H2: begin kind = PK_D16; lane = 3'h4; end
      `TSW_STRB_H3: begin kind = PK_D16; lane = 3'h6; end
      `TSW_STRB_W0: kind = PK_D32;
      `TSW_STRB_W1: begin kind = PK_D32; lane = 3'h4; end
      `TSW_STRB_D0: kind = PK_D64;
      // zero strobes and illegal patterns produce nothing
      default: kind = PK_NONE;
    endcase
    shifted = wdata >> {lane, 3'h0};
    // lanes above the packet size are cleared so no stale byte rides along
    case (kind)
      PK_D8: payload = {56'h0, shifted[7:0]};
      PK_D16: payload = {48'h0, shifted[15:0]};
      PK_D32: payload = {32'h0, shifted[31:0]};
      PK_D64: payload = shifted;
      default: payload = 64'h0;
    endcase
  end
endmodule
`default_nettype wire

// file: design/trace_stimulus_write_filter.sv
`default_nettype none
`include "tsw_consts.svh"
module trace_stimulus_write_filter #(
  parameter int ADDR_W = 32,
  parameter int ID_W = 4,
  parameter int PORTS = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [ID_W-1:0] awid,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [7:0] awlen,
  input wire logic [2:0] awsize,
  input wire logic [1:0] awburst,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [63:0] wdata,
  input wire logic [7:0] wstrb,
  input wire logic wlast,
  input wire logic wvalid,
  output logic wready,
  output logic [ID_W-1:0] bid,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ID_W-1:0] arid,
  input wire logic [7:0] arlen,
  input wire logic arvalid,
  output logic arready,
  output logic [ID_W-1:0] rid,
  output logic [63:0] rdata,
  output logic [1:0] rresp,
  output logic rlast,
  output logic rvalid,
  input wire logic rready,
  input wire logic trace_enable,
  input wire logic [PORTS-1:0] port_enable_control,
  input wire logic [PORTS-1:0] port_select_control,
  input wire tsw_pkg::ovr_mode_t port_override_control,
  input wire logic nonsecure_guarantee_enable,
  input wire logic invasive_debug_permit,
  input wire logic noninvasive_debug_permit,
  input wire logic secure_invasive_permit,
  input wire logic secure_noninvasive_permit,
  output logic pkt_valid,
  input wire logic pkt_ready,
  output tsw_pkg::pkt_kind_t pkt_kind,
  output logic [7:0] pkt_master,
  output logic [63:0] pkt_data
);
  import tsw_pkg::*;
  localparam int PIW = (PORTS > 1) ? $clog2(PORTS) : 1;
  localparam int FW = 3 + 8 + 64;
  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [LW:0] ROOM = (LW + 1)'(DEPTH);

  logic rst_a_r, rst_n;
  // reset enters asynchronously but is released only after two edges
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_a_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n <= rst_a_r;
    end
  end

  // pin-level permits: three stages, a bit moves once stages two and three agree
  logic [4:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r, pin_nxt;
  always_comb begin
    pin_nxt = (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r ^ pin_s3_r));
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_r <= '0;
    end else begin
      pin_s1_r <= {nonsecure_guarantee_enable, invasive_debug_permit,
                   noninvasive_debug_permit, secure_invasive_permit, secure_noninvasive_permit};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r <= pin_nxt;
    end
  end

  // permitted debug levels per security state
  logic ns_guar_en, inv_ns, inv_s, nin_ns, nin_s;
  assign ns_guar_en = pin_r[4];
  assign inv_ns = pin_r[3];
  assign inv_s = pin_r[3] & pin_r[1];
  assign nin_ns = pin_r[3] | pin_r[2];
  assign nin_s = nin_ns & (pin_r[1] | pin_r[0]);

  // classify a beat: bit 1 guaranteed, bit 0 dropped; prot[0] and prot[2] never read
  function automatic logic [1:0] classify(input logic [ADDR_W-1:0] a, input logic ns);
    logic [PIW-1:0] idx;
    logic drop, guar;
    idx = a[`TSW_CHAN_LSB +: PIW];
    drop = !trace_enable || !port_enable_control[idx] || !(ns ? nin_ns : nin_s);
    guar = !a[`TSW_INV_SEL_BIT];
    if (ns && !ns_guar_en) begin
      guar = 1'b0;
    end
    if (port_select_control[idx]) begin
      if (port_override_control == OVR_GUARANTEED && (ns ? inv_ns : inv_s)) begin
        guar = 1'b1;
      end else if (port_override_control == OVR_INVARIANT) begin
        guar = 1'b0;
      end
    end
    return {guar, drop};
  endfunction

  // decode and buffer
  pkt_kind_t dec_kind, out_kind;
  logic [63:0] dec_data;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [FW-1:0] fifo_in_data, fifo_out_data;
  logic [LW-1:0] fifo_level;

  strobe_decode u_dec (
    .strb(wstrb),
    .wdata(wdata),
    .kind(dec_kind),
    .payload(dec_data)
  );

  tsw_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // write channel state
  wr_state_t wst_r, wst_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic ns_r, ns_nxt;
  logic [2:0] size_r, size_nxt;
  logic [1:0] burst_r, burst_nxt;
  logic [ID_W-1:0] bid_nxt;
  logic awready_nxt, wready_nxt, bvalid_nxt;
  logic [1:0] cls_cur, cls_nxt;
  logic wfire, data_push, lost, err_push, room;
  logic [7:0] mid_cur;

  // a process, not an assign: the class also follows enables read inside classify
  always_comb begin
    cls_cur = classify(addr_r, ns_r);
  end
  assign mid_cur = {1'b0, ns_r, addr_r[`TSW_MID_HI:`TSW_MID_LO]};
  assign wfire = (wst_r == WR_DATA) && wvalid && wready;
  assign data_push = wfire && !cls_cur[0] && dec_kind != PK_NONE && fifo_in_ready;
  assign lost = wfire && !cls_cur[0] && dec_kind != PK_NONE && !fifo_in_ready;

  // next beat state; wready is registered, so room is judged one cycle ahead
  always_comb begin
    wst_nxt = wst_r;
    addr_nxt = addr_r;
    ns_nxt = ns_r;
    size_nxt = size_r;
    burst_nxt = burst_r;
    bid_nxt = bid;
    bvalid_nxt = bvalid;
    case (wst_r)
      WR_ADDR: begin
        if (awvalid && awready) begin
          addr_nxt = awaddr;
          ns_nxt = awprot[`TSW_PROT_NS_BIT];
          size_nxt = awsize;
          burst_nxt = awburst;
          bid_nxt = awid;
          wst_nxt = WR_DATA;
        end
      end
      WR_DATA: begin
        if (wfire) begin
          if (wlast) begin
            wst_nxt = WR_RESP;
            bvalid_nxt = 1'b1;
          end else if (burst_r == `TSW_BURST_INCR) begin
            addr_nxt = addr_r + (ADDR_W'(1) << size_r);
          end
        end
      end
      WR_RESP: begin
        if (bready) begin
          wst_nxt = WR_ADDR;
          bvalid_nxt = 1'b0;
        end
      end
      default: wst_nxt = WR_ADDR;
    endcase
    cls_nxt = classify(addr_nxt, ns_nxt);
    room = ({1'b0, fifo_level} + (LW + 1)'(fifo_in_valid)) < ROOM;
    awready_nxt = (wst_nxt == WR_ADDR);
    // invariant and dropped beats never wait; guaranteed ones wait for room
    wready_nxt = (wst_nxt == WR_DATA) && (!cls_nxt[1] || cls_nxt[0] || room);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_r <= WR_ADDR;
      addr_r <= '0;
      ns_r <= 1'b0;
      size_r <= 3'h0;
      burst_r <= 2'h0;
      bid <= '0;
      bvalid <= 1'b0;
      bresp <= `TSW_RESP_OKAY;
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      wst_r <= wst_nxt;
      addr_r <= addr_nxt;
      ns_r <= ns_nxt;
      size_r <= size_nxt;
      burst_r <= burst_nxt;
      bid <= bid_nxt;
      bvalid <= bvalid_nxt;
      bresp <= `TSW_RESP_OKAY;
      awready <= awready_nxt;
      wready <= wready_nxt;
    end
  end

  // overflow error tracking
  logic err_pend_r, err_pend_nxt, err_glob_r, err_glob_nxt, quiet_r, quiet_nxt;
  logic [7:0] err_mid_r, err_mid_nxt;
  assign err_push = err_pend_r && !data_push && fifo_in_ready;
  assign fifo_in_valid = data_push || err_push;
  always_comb begin
    if (err_push) begin
      fifo_in_data = {err_glob_r ? PK_GLOBAL_ERROR_PACKET : PK_MASTER_ERROR_PACKET, err_mid_r, 56'h0, `TSW_ERR_PAYLOAD};
    end else begin
      fifo_in_data = {dec_kind, mid_cur, dec_data};
    end
  end

  // after an error push and before the next data push, a loss is kept only if it comes from another master
  always_comb begin
    err_pend_nxt = err_pend_r;
    err_glob_nxt = err_glob_r;
    err_mid_nxt = err_mid_r;
    quiet_nxt = quiet_r;
    if (err_push) begin
      err_pend_nxt = 1'b0;
      err_glob_nxt = 1'b0;
      quiet_nxt = 1'b1;
    end
    if (data_push) begin
      quiet_nxt = 1'b0;
    end
    if (lost) begin
      if (err_pend_r && !err_push) begin
        if (mid_cur != err_mid_r) begin
          err_glob_nxt = 1'b1;
        end
      end else if (!quiet_nxt || mid_cur != err_mid_r) begin
        err_pend_nxt = 1'b1;
        err_mid_nxt = mid_cur;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_pend_r <= 1'b0;
      err_glob_r <= 1'b0;
      err_mid_r <= 8'h00;
      quiet_r <= 1'b0;
    end else begin
      err_pend_r <= err_pend_nxt;
      err_glob_r <= err_glob_nxt;
      err_mid_r <= err_mid_nxt;
      quiet_r <= quiet_nxt;
    end
  end

  // output stage keeps every packet output on a flop
  logic pkt_valid_nxt;
  assign fifo_out_ready = !pkt_valid || pkt_ready;
  assign out_kind = pkt_kind_t'(fifo_out_data[FW-1 -: 3]);
  always_comb begin
    pkt_valid_nxt = fifo_out_ready ? fifo_out_valid : pkt_valid;
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_valid <= 1'b0;
      pkt_kind <= PK_NONE;
      pkt_master <= 8'h00;
      pkt_data <= 64'h0;
    end else begin
      pkt_valid <= pkt_valid_nxt;
      if (fifo_out_ready && fifo_out_valid) begin
        pkt_kind <= out_kind;
        pkt_master <= fifo_out_data[71:64];
        pkt_data <= fifo_out_data[63:0];
      end
    end
  end

  // read channel: write-only space, so every beat is zero data and OKAY
  rd_state_t rst_r, rst_nxt;
  logic [7:0] rcnt_r, rcnt_nxt;
  logic [ID_W-1:0] rid_nxt;
  logic arready_nxt, rvalid_nxt, rlast_nxt;
  always_comb begin
    rst_nxt = rst_r;
    rcnt_nxt = rcnt_r;
    rid_nxt = rid;
    case (rst_r)
      RD_ADDR: begin
        if (arvalid && arready) begin
          rst_nxt = RD_DATA;
          rcnt_nxt = arlen;
          rid_nxt = arid;
        end
      end
      RD_DATA: begin
        if (rready) begin
          if (rcnt_r == 8'h00) begin
            rst_nxt = RD_ADDR;
          end else begin
            rcnt_nxt = rcnt_r - 8'h01;
          end
        end
      end
      default: rst_nxt = RD_ADDR;
    endcase
    arready_nxt = (rst_nxt == RD_ADDR);
    rvalid_nxt = (rst_nxt == RD_DATA);
    rlast_nxt = (rst_nxt == RD_DATA) && (rcnt_nxt == 8'h00);
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_r <= RD_ADDR;
      rcnt_r <= 8'h00;
      rid <= '0;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rlast <= 1'b0;
      rdata <= 64'h0;
      rresp <= `TSW_RESP_OKAY;
    end else begin
      rst_r <= rst_nxt;
      rcnt_r <= rcnt_nxt;
      rid <= rid_nxt;
      arready <= arready_nxt;
      rvalid <= rvalid_nxt;
      rlast <= rlast_nxt;
      rdata <= 64'h0;
      rresp <= `TSW_RESP_OKAY;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_read_zero: assert property (rvalid |-> rdata == 64'h0 && rresp == `TSW_RESP_OKAY)
    else $error("read beat not zero okay");
  chk_bresp_okay: assert property (bvalid |-> bresp == `TSW_RESP_OKAY)
    else $error("write response not okay");
  chk_err_payload: assert property (pkt_valid && (pkt_kind == PK_MASTER_ERROR_PACKET || pkt_kind == PK_GLOBAL_ERROR_PACKET)
    |-> pkt_data[7:0] == `TSW_ERR_PAYLOAD)
    else $error("error packet payload not zero");
  chk_nostall_drop: assert property (wst_r == WR_DATA && $stable(addr_r) && $past(wst_r) == WR_DATA
    && (cls_cur[0] || !cls_cur[1]) && $stable(cls_cur) |-> wready)
    else $error("dropped or invariant beat stalled");
  chk_drop_silent: assert property (wfire && cls_cur[0] |-> !data_push && !lost)
    else $error("dropped beat reached buffer");
  chk_zero_strobe: assert property (wfire && wstrb == 8'h00 |-> !data_push)
    else $error("zero strobe beat made a packet");
  chk_guar_room: assert property (wfire && cls_cur[1] && !cls_cur[0] && $stable(cls_cur)
    && dec_kind != PK_NONE |-> fifo_in_ready)
    else $error("guaranteed beat accepted without room");
  chk_master_id: assert property (data_push |-> fifo_in_data[71:64] == {1'b0, ns_r, addr_r[29:24]})
    else $error("pushed packet carries wrong master");
  chk_glob_cause: assert property ($rose(err_glob_r) |-> $past(lost) && $past(err_pend_r))
    else $error("global error without pending loss");
  chk_loss_marks: assert property (lost && !err_pend_r && !quiet_r |=> err_pend_r)
    else $error("loss did not raise master error");

  cov_guar_stall: cover property (wst_r == WR_DATA && wvalid && !wready ##1 wfire);
  cov_master_error_packet_out: cover property (pkt_valid && pkt_kind == PK_MASTER_ERROR_PACKET);
  cov_global_error_packet_out: cover property (pkt_valid && pkt_kind == PK_GLOBAL_ERROR_PACKET);
  cov_read_burst: cover property (rvalid && rlast && rready);
endmodule
`default_nettype wire

// file: tb/axi_writer.sv
`default_nettype none
module axi_writer (
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [31:0] addr,
  input wire logic [2:0] prot,
  input wire logic [7:0] strb,
  input wire logic [63:0] data,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic [1:0] bresp,
  output logic done,
  output logic [1:0] resp,
  output logic [31:0] awaddr,
  output logic [2:0] awprot,
  output logic awvalid,
  output logic [63:0] wdata,
  output logic [7:0] wstrb,
  output logic wlast,
  output logic wvalid,
  output logic bready
);
  timeunit 1ns;
  timeprecision 1ps;
  // two-beat burst: an empty first beat lets any lane pattern follow it
  initial begin
    {done, awvalid, wvalid, wlast, bready, awprot, wstrb} = '0;
    {resp, awaddr, wdata} = '0;
    forever begin
      @(posedge ref_clk);
      done <= 1'b0;
      if (go) begin
        awaddr <= addr;
        awprot <= prot;
        awvalid <= 1'b1;
        do @(posedge ref_clk); while (!awready);
        awvalid <= 1'b0;
        awaddr <= ~addr;
        wvalid <= 1'b1;
        do @(posedge ref_clk); while (!wready);
        wstrb <= strb;
        wdata <= data;
        wlast <= 1'b1;
        do @(posedge ref_clk); while (!wready);
        {wvalid, wlast, wstrb} <= '0;
        // released data lines flip so stale lanes never look valid
        wdata <= ~data;
        bready <= 1'b1;
        do @(posedge ref_clk); while (!bvalid);
        bready <= 1'b0;
        resp <= bresp;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
`default_nettype none
`include "tsw_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tsw_pkg::*;
  logic ref_clk = 0, nrst = 0, go = 0, pkt_ready = 1, arvalid = 0, rready = 0, ten = 1;
  logic ngen = 1, dbg = 1, nid = 1, spid = 1, spnid = 1, st;
  logic done, awvalid, awready, wvalid, wready, wlast, bvalid, bready, arready, rvalid, rlast;
  logic pkt_valid;
  logic [31:0] addr = 0, pen = '1, psel = 0, awaddr;
  logic [2:0] prot = 0, awprot;
  logic [7:0] strb = 0, arlen = 8'h01, wstrb, pkt_master, last_master;
  logic [63:0] data = 64'h8877665544332211, wdata, rdata, pkt_data, last_data;
  logic [1:0] resp, bresp, rresp;
  logic [3:0] bid, rid;
  ovr_mode_t ovr = OVR_NONE;
  pkt_kind_t pkt_kind, last_kind;
  int n_errors = 0, checks_done = 0, n_pkts = 0, cycles = 0;
  logic [7:0] strbs [16] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
    8'h03, 8'h0C, 8'h30, 8'hC0, 8'h0F, 8'hF0, 8'hFF, 8'h00};

  trace_stimulus_write_filter dut (.ref_clk(ref_clk), .nrst(nrst), .awid(4'h3),
    .awaddr(awaddr), .awlen(8'h01), .awsize(3'h1), .awburst(2'h1), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wlast(wlast),
    .wvalid(wvalid), .wready(wready), .bid(bid), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arid(4'h5), .arlen(arlen), .arvalid(arvalid), .arready(arready), .rid(rid), .rdata(rdata),
    .rresp(rresp), .rlast(rlast), .rvalid(rvalid), .rready(rready), .trace_enable(ten),
    .port_enable_control(pen), .port_select_control(psel), .port_override_control(ovr),
    .nonsecure_guarantee_enable(ngen), .invasive_debug_permit(dbg),
    .noninvasive_debug_permit(nid), .secure_invasive_permit(spid),
    .secure_noninvasive_permit(spnid), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
    .pkt_kind(pkt_kind), .pkt_master(pkt_master), .pkt_data(pkt_data));

  axi_writer writer (.ref_clk(ref_clk), .go(go), .addr(addr), .prot(prot), .strb(strb),
    .data(data), .awready(awready), .wready(wready), .bvalid(bvalid), .bresp(bresp),
    .done(done), .resp(resp), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .wdata(wdata), .wstrb(wstrb), .wlast(wlast), .wvalid(wvalid), .bready(bready));

  always #2 ref_clk = ~ref_clk;

  // record every packet taken, and cut a hung run short
  always @(posedge ref_clk) begin
    cycles++;
    if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
      n_pkts++;
      last_kind <= pkt_kind;
      last_data <= pkt_data;
      last_master <= pkt_master;
    end
    if (cycles == 8000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a write that does not finish in 40 cycles is a stall; the sink then opens
  task automatic burst(input logic [31:0] a, input logic [2:0] p, input logic [7:0] s);
    int k;
    addr <= a;
    prot <= p;
    strb <= s;
    go <= 1'b1;
    st = 1'b0;
    @(posedge ref_clk);
    go <= 1'b0;
    for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge ref_clk);
    if (done !== 1'b1) begin
      st = 1'b1;
      pkt_ready <= 1'b1;
      for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge ref_clk);
    end
    cmp(resp, `TSW_RESP_OKAY);
    cmp(bid, 4'h3);
  endtask

  task automatic single(input logic [2:0] p, input int en, input logic [7:0] em);
    int n0;
    repeat (10) @(posedge ref_clk);
    n0 = n_pkts;
    burst(32'h2A000305, p, 8'hFF);
    repeat (4) @(posedge ref_clk);
    cmp(n_pkts - n0, en);
    if (en > 0) cmp(last_master, em);
  endtask

  // twelve writes into a closed sink: more than the buffer holds
  task automatic flood(input logic g, input ovr_mode_t om, input logic d,
    input logic [31:0] a, input logic [31:0] al, input logic es, input pkt_kind_t ek);
    int ns;
    ngen <= g;
    ovr <= om;
    dbg <= d;
    psel <= 32'h1;
    pkt_ready <= 1'b0;
    repeat (10) @(posedge ref_clk);
    ns = 0;
    for (int i = 0; i < 12; i++) begin
      burst(i == 11 ? al : a, 3'b010, 8'hFF);
      ns += st;
    end
    pkt_ready <= 1'b1;
    repeat (40) @(posedge ref_clk);
    cmp(ns > 0, es);
    cmp(last_kind, ek);
    if (ek != PK_D64) cmp(last_data, `TSW_ERR_PAYLOAD);
  endtask

  initial begin
    int n0, n, lo;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    // every lane pattern, low address bits and beat size deliberately off
    foreach (strbs[i]) begin
      n0 = n_pkts;
      n = $countones(strbs[i]);
      for (lo = 0; lo < 7 && !strbs[i][lo]; lo++);
      burst(32'h2A000305, 3'b011, strbs[i]);
      repeat (4) @(posedge ref_clk);
      cmp(n_pkts - n0, n > 0);
      if (n > 0) begin
        cmp(last_kind, n == 1 ? PK_D8 : n == 2 ? PK_D16 : n == 4 ? PK_D32 : PK_D64);
        cmp(last_data, (data >> (8 * lo)) & ~({64{1'b1}} << (8 * n)));
        cmp(last_master, 8'h6A);
      end
    end
    $display("test lanes done");
    pen <= 32'hFFFF_FFF7;
    single(3'b011, 0, 8'h00);
    pen <= '1;
    spid <= 1'b0;
    spnid <= 1'b0;
    single(3'b101, 0, 8'h00);
    spnid <= 1'b1;
    single(3'b101, 1, 8'h2A);
    ten <= 1'b0;
    single(3'b011, 0, 8'h00);
    ten <= 1'b1;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      cmp(rdata, 64'h0);
      cmp({rresp, rlast}, {2'h0, b == 1});
      cmp(rid, 4'h5);
    end
    rready <= 1'b0;
    $display("test filters done");
    flood(1, OVR_NONE, 1, 32'h2A000000, 32'h2A000000, 1, PK_D64);
    flood(0, OVR_NONE, 1, 32'h2A000000, 32'h2A000000, 0, PK_MASTER_ERROR_PACKET);
    flood(1, OVR_INVARIANT, 0, 32'h2A000000, 32'h2A000000, 0, PK_MASTER_ERROR_PACKET);
    flood(0, OVR_GUARANTEED, 0, 32'h2A000000, 32'h2A000000, 0, PK_MASTER_ERROR_PACKET);
    flood(0, OVR_GUARANTEED, 1, 32'h2A000000, 32'h2A000000, 1, PK_D64);
    flood(1, OVR_NONE, 1, 32'h2A000080, 32'h15000080, 0, PK_GLOBAL_ERROR_PACKET);
    $display("test overflow done");
    print_verdict();
  end
endmodule
`default_nettype wire
